//--- adc_ctrl.sv
`include "adc_ctrl_defs.svh"
`default_nettype none
module adc_ctrl #(
   parameter int STARTUP_CYCLES = `STARTUP_CYCLES,
   parameter int FIFO_DEPTH = `FIFO_DEPTH,
   parameter int DELAY_WIDTH = 8
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic [23:0] busAddr,
   input wire logic busWrite,
   input wire logic busRead,
   input wire logic [15:0] busWData,
   output logic [15:0] busRData_q,
   output logic busAck_q,
   input wire logic freezePin,
   input wire logic asyncTrigPin,
   input wire logic penDownPin,
   input wire logic convDone,
   input wire logic [11:0] convData,
   output logic convStart_q,
   output logic converterReady_q,
   output logic analogPowerUp_q,
   output logic convClockEnable_q,
   output logic auxClockSelect_q,
   output logic [1:0] clockDivSelect_q,
   output logic inputSourceSelect_q,
   output logic differentialSelect_q,
   output logic [2:0] channelSelect_q,
   output logic muxOutputEnable_q,
   output logic [3:0] positiveRefSelect_q,
   output logic [3:0] negativeRefSelect_q,
   output logic [4:0] plateDrive_q,
   output logic converterIrqLine_q,
   output logic converterWakeupLine_q
);
   localparam int SCW = (STARTUP_CYCLES > 1) ? $clog2(STARTUP_CYCLES + 1) : 1;
   if (STARTUP_CYCLES < 1) begin : g_bad_startup
      $error("adc_ctrl start-up count must be at least one cycle");
   end
   if (DELAY_WIDTH < 1 || DELAY_WIDTH > 16) begin : g_bad_delay
      $error("adc_ctrl delay width must lie in 1..16");
   end

   // address decoder shared by read and write paths
   function automatic adc_ctrl_pkg::reg_sel_t decode(input logic [23:0] addr);
      if (addr == `GLB_ADDR) begin
         decode = adc_ctrl_pkg::SEL_GLOBAL;
      end else if (addr == `AUX_ADDR) begin
         decode = adc_ctrl_pkg::SEL_AUX;
      end else if (addr == `TRIG_ADDR) begin
         decode = adc_ctrl_pkg::SEL_TRIGGER;
      end else if (addr == `START_ADDR) begin
         decode = adc_ctrl_pkg::SEL_START;
      end else if (addr == `DLY_ADDR) begin
         decode = adc_ctrl_pkg::SEL_DELAY;
      end else if (addr == `RES_ADDR) begin
         decode = adc_ctrl_pkg::SEL_RESULT;
      end else begin
         decode = adc_ctrl_pkg::SEL_NONE;
      end
   endfunction

   // two-bit reference code to one-hot source select
   function automatic logic [3:0] oneHot4(input logic [1:0] code);
      oneHot4 = 4'h1 << code;
   endfunction

   // plate drivers: {xPosHigh, xPosWeak, yPosHigh, xNegLow, yNegLow}
   function automatic logic [4:0] touchDrive(input logic [2:0] mode);
      case (mode)
         3'h1: touchDrive = 5'b00101;
         3'h2: touchDrive = 5'b10010;
         3'h3: touchDrive = 5'b10001;
         3'h4: touchDrive = 5'b00110;
         3'h5: touchDrive = 5'b01001;
         default: touchDrive = 5'b00000;
      endcase
   endfunction

   logic [15:0] global_q;
   logic [2:0] auxCfg_q;
   logic [2:0] trigCtl_q;
   logic [15:0] startDelay_q;
   logic [2:0] pinMeta_q;
   logic [2:0] pinSync_q;
   logic asyncPrev_q;
   logic [SCW-1:0] startupCnt_q;
   logic primed_q;
   logic overflow_q;
   logic [DELAY_WIDTH-1:0] delayCnt_q;
   adc_ctrl_pkg::conv_state_t state_q;
   adc_ctrl_pkg::reg_sel_t sel;
   logic enabled;
   logic writeOpen;
   logic startWrite;
   logic freezeSync;
   logic asyncSync;
   logic penSync;
   logic asyncEdge;
   logic trigger;
   logic resultRead;
   logic pushValid;
   logic [11:0] pushData;
   logic fifoFull;
   logic fifoEmpty;
   logic [11:0] headData;
   logic penShown;
   logic [15:0] readValue;

   assign sel = decode(busAddr);
   assign enabled = global_q[`GLB_ENABLE_BIT];
   assign freezeSync = pinSync_q[0];
   assign asyncSync = pinSync_q[1];
   assign penSync = pinSync_q[2];

   // write lock while disabled, config registers excepted
   assign writeOpen = enabled || (sel == adc_ctrl_pkg::SEL_GLOBAL)
      || (sel == adc_ctrl_pkg::SEL_AUX);
   assign startWrite = busWrite && enabled && (sel == adc_ctrl_pkg::SEL_START);

   // global configuration register
   always_ff @(posedge clock) begin
      if (rst) begin
         global_q <= `GLB_RESET;
      end else if (busWrite && (sel == adc_ctrl_pkg::SEL_GLOBAL)) begin
         global_q <= busWData & `GLB_WMASK;
      end
   end

   // auxiliary clock configuration, always writeable
   always_ff @(posedge clock) begin
      if (rst) begin
         auxCfg_q <= `AUX_RESET;
      end else if (busWrite && (sel == adc_ctrl_pkg::SEL_AUX)) begin
         auxCfg_q <= busWData[2:0];
      end
   end

   // trigger control and start delay, locked while disabled
   always_ff @(posedge clock) begin
      if (rst) begin
         trigCtl_q <= `TRIG_RESET;
         startDelay_q <= `DLY_RESET;
      end else if (busWrite && writeOpen) begin
         if (sel == adc_ctrl_pkg::SEL_TRIGGER) begin
            trigCtl_q <= busWData[2:0];
         end
         if (sel == adc_ctrl_pkg::SEL_DELAY) begin
            startDelay_q <= busWData;
         end
      end
   end

   // two-stage synchronisers for freeze, trigger and pen-down pins
   always_ff @(posedge clock) begin
      if (rst) begin
         pinMeta_q <= 3'h0;
         pinSync_q <= 3'h0;
         asyncPrev_q <= 1'b0;
      end else begin
         pinMeta_q <= {penDownPin, asyncTrigPin, freezePin};
         pinSync_q <= pinMeta_q;
         asyncPrev_q <= asyncSync;
      end
   end

   // edge of chosen polarity on the external trigger
   assign asyncEdge = trigCtl_q[`TRIG_POL_BIT] ? (asyncPrev_q && !asyncSync)
      : (!asyncPrev_q && asyncSync);

   // start-up timer after enable
   always_ff @(posedge clock) begin
      if (rst || !enabled) begin
         startupCnt_q <= '0;
         converterReady_q <= 1'b0;
      end else if (!converterReady_q) begin
         startupCnt_q <= SCW'(startupCnt_q + 1'b1);
         converterReady_q <= (startupCnt_q == SCW'(STARTUP_CYCLES - 1));
      end
   end

   // accepted only when idle, so one trigger per conversion
   assign trigger = converterReady_q && (state_q == adc_ctrl_pkg::ST_IDLE)
      && (trigCtl_q[`TRIG_EXT_BIT]
         ? (asyncEdge && (trigCtl_q[`TRIG_AUTO_BIT] || primed_q))
         : startWrite);

   // prime flag for non-automatic external triggering
   always_ff @(posedge clock) begin
      if (rst || !enabled) begin
         primed_q <= 1'b0;
      end else if (startWrite && trigCtl_q[`TRIG_EXT_BIT] && !trigCtl_q[`TRIG_AUTO_BIT]) begin
         primed_q <= 1'b1; // a prime in the completion cycle wins
      end else if (pushValid) begin
         primed_q <= 1'b0;
      end
   end

   // conversion sequencer: delay, start pulse, wait for done
   always_ff @(posedge clock) begin
      if (rst || !enabled) begin
         state_q <= adc_ctrl_pkg::ST_IDLE;
         delayCnt_q <= '0;
         convStart_q <= 1'b0;
      end else begin
         convStart_q <= 1'b0;
         case (state_q)
            adc_ctrl_pkg::ST_IDLE: begin
               if (trigger) begin
                  state_q <= adc_ctrl_pkg::ST_DELAY;
                  delayCnt_q <= startDelay_q[DELAY_WIDTH-1:0];
               end
            end
            adc_ctrl_pkg::ST_DELAY: begin
               if (delayCnt_q == '0) begin
                  state_q <= adc_ctrl_pkg::ST_CONVERT;
                  convStart_q <= 1'b1;
               end else begin
                  delayCnt_q <= DELAY_WIDTH'(delayCnt_q - 1'b1);
               end
            end
            adc_ctrl_pkg::ST_CONVERT: begin
               if (convDone) begin
                  state_q <= adc_ctrl_pkg::ST_IDLE;
               end
            end
            default: begin
               state_q <= adc_ctrl_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // completed results enter the queue, freeze or not
   assign pushValid = enabled && convDone && (state_q == adc_ctrl_pkg::ST_CONVERT);
   assign pushData = (global_q[`GLB_DIFFSEL_BIT] || (convData <= `SINGLE_MAX))
      ? convData : `SINGLE_MAX;

   // result read pops unless frozen
   assign resultRead = busRead && (sel == adc_ctrl_pkg::SEL_RESULT);

   // queue on the system clock; results surface only through it
   result_fifo #(
      .WIDTH(`RESULT_WIDTH),
      .DEPTH(FIFO_DEPTH)
   ) u_result_fifo (
      .clock(clock),
      .rst(rst),
      .pushValid(pushValid),
      .pushData(pushData),
      .pop(resultRead && !freezeSync),
      .full(fifoFull),
      .empty(fifoEmpty),
      .headData_q(headData)
   );

   // overflow flag, set wins over read clear
   always_ff @(posedge clock) begin
      if (rst) begin
         overflow_q <= 1'b0;
      end else if (pushValid && fifoFull) begin
         overflow_q <= 1'b1;
      end else if (resultRead && !freezeSync) begin
         overflow_q <= 1'b0;
      end
   end

   // pen-down visible only in detect mode
   assign penShown = penSync
      && (global_q[`GLB_TOUCH_LSB +: 3] == `TOUCH_PEN_DETECT);

   // read multiplexer, unmapped and write-only read as zero
   always_comb begin
      readValue = 16'h0000;
      if (sel == adc_ctrl_pkg::SEL_GLOBAL) begin
         readValue = global_q;
      end else if (sel == adc_ctrl_pkg::SEL_AUX) begin
         readValue[2:0] = auxCfg_q;
         readValue[`AUX_PRIMED_BIT] = primed_q;
         readValue[`AUX_TRIGGERED_BIT] = (state_q != adc_ctrl_pkg::ST_IDLE);
         readValue[`AUX_CONVERTING_BIT] = (state_q == adc_ctrl_pkg::ST_CONVERT);
      end else if (sel == adc_ctrl_pkg::SEL_TRIGGER) begin
         readValue[2:0] = trigCtl_q;
      end else if (sel == adc_ctrl_pkg::SEL_DELAY) begin
         readValue = startDelay_q;
      end else if (sel == adc_ctrl_pkg::SEL_RESULT) begin
         readValue[11:0] = headData;
         readValue[`RES_OVERFLOW_BIT] = overflow_q;
         readValue[`RES_PEN_BIT] = penShown;
         readValue[`RES_DONE_BIT] = !fifoEmpty;
      end
   end

   // bus answer one cycle after any access
   always_ff @(posedge clock) begin
      if (rst) begin
         busRData_q <= 16'h0000;
         busAck_q <= 1'b0;
      end else begin
         busAck_q <= busRead || busWrite;
         if (busRead) begin
            busRData_q <= readValue;
         end
      end
   end

   // done interrupt follows queue while the irq enable bit is set, wake-up follows queue or shown pen-down; queue terms gap after each read
   always_ff @(posedge clock) begin
      if (rst) begin
         converterIrqLine_q <= 1'b0;
         converterWakeupLine_q <= 1'b0;
      end else begin
         converterIrqLine_q <= global_q[`GLB_IRQEN_BIT] && !fifoEmpty && !resultRead;
         converterWakeupLine_q <= (!fifoEmpty && !resultRead) || penShown;
      end
   end

   // analog power, clock gating and routing outputs
   always_ff @(posedge clock) begin
      if (rst) begin
         analogPowerUp_q <= 1'b0;
         convClockEnable_q <= 1'b0;
         auxClockSelect_q <= 1'b0;
         clockDivSelect_q <= 2'h0;
         inputSourceSelect_q <= 1'b0;
         differentialSelect_q <= 1'b0;
         channelSelect_q <= 3'h0;
         muxOutputEnable_q <= 1'b0;
         positiveRefSelect_q <= 4'h1;
         negativeRefSelect_q <= 4'h1;
         plateDrive_q <= 5'h00;
      end else begin
         analogPowerUp_q <= enabled;
         convClockEnable_q <= enabled;
         auxClockSelect_q <= auxCfg_q[`AUX_CLKSEL_BIT];
         clockDivSelect_q <= auxCfg_q[`AUX_DIV_LSB +: 2];
         inputSourceSelect_q <= global_q[`GLB_SRC_BIT];
         differentialSelect_q <= global_q[`GLB_DIFFSEL_BIT];
         channelSelect_q <= global_q[`GLB_CHAN_LSB +: 3];
         muxOutputEnable_q <= global_q[`GLB_MUXOE_BIT];
         positiveRefSelect_q <= oneHot4(global_q[`GLB_PREF_LSB +: 2]);
         negativeRefSelect_q <= oneHot4(global_q[`GLB_NREF_LSB +: 2]);
         plateDrive_q <= enabled ? touchDrive(global_q[`GLB_TOUCH_LSB +: 3]) : 5'h00;
      end
   end
endmodule
`default_nettype wire

//--- adc_ctrl_defs.svh
`ifndef ADC_CTRL_DEFS_SVH
`define ADC_CTRL_DEFS_SVH

// register addresses
`define GLB_ADDR 24'hFF_F3C0
`define AUX_ADDR 24'hFF_F3C2
`define TRIG_ADDR 24'hFF_F3C4
`define START_ADDR 24'hFF_F3C6
`define DLY_ADDR 24'hFF_F3C8
`define RES_ADDR 24'hFF_F3CA

// global configuration fields
`define GLB_RESET 16'h0000
`define GLB_WMASK 16'hDFFF
`define GLB_ENABLE_BIT 0
`define GLB_SRC_BIT 1
`define GLB_DIFFSEL_BIT 2
`define GLB_CHAN_LSB 3
`define GLB_TOUCH_LSB 6
`define GLB_PREF_LSB 9
`define GLB_NREF_LSB 11
`define GLB_IRQEN_BIT 14
`define GLB_MUXOE_BIT 15
`define TOUCH_PEN_DETECT 3'h5

// auxiliary configuration fields
`define AUX_RESET 3'h0
`define AUX_CLKSEL_BIT 0
`define AUX_DIV_LSB 1
`define AUX_PRIMED_BIT 13
`define AUX_TRIGGERED_BIT 14
`define AUX_CONVERTING_BIT 15

// trigger control fields
`define TRIG_RESET 3'h0
`define TRIG_POL_BIT 0
`define TRIG_EXT_BIT 1
`define TRIG_AUTO_BIT 2

// start delay and result fields
`define DLY_RESET 16'h0000
`define RES_OVERFLOW_BIT 13
`define RES_PEN_BIT 14
`define RES_DONE_BIT 15
`define RESULT_WIDTH 12
`define SINGLE_MAX 12'h7FF
`define FIFO_DEPTH 4

// timing
`define CLOCK_MHZ 200
`define STARTUP_TIME_NS 250
`define STARTUP_CYCLES ((`STARTUP_TIME_NS * `CLOCK_MHZ + 999) / 1000)

`endif

//--- adc_ctrl_pkg.sv
`default_nettype none
package adc_ctrl_pkg;
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_DELAY,
      ST_CONVERT
   } conv_state_t;
   typedef enum logic [2:0] {
      SEL_GLOBAL,
      SEL_AUX,
      SEL_TRIGGER,
      SEL_START,
      SEL_DELAY,
      SEL_RESULT,
      SEL_NONE
   } reg_sel_t;
endpackage
`default_nettype wire

//--- result_fifo.sv
`default_nettype none
module result_fifo #(
   parameter int WIDTH = 12,
   parameter int DEPTH = 4
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic pushValid,
   input wire logic [WIDTH-1:0] pushData,
   input wire logic pop,
   output logic full,
   output logic empty,
   output logic [WIDTH-1:0] headData_q
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("result_fifo depth must be a power of two, at least 2");
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] wrPtr_q;
   logic [PW-1:0] rdPtr_q;
   logic [PW:0] count_q;
   logic doPush;
   logic doPop;
   logic [PW-1:0] rdPtrNext;

   // accept only with room, pop only with data
   assign full = (count_q == (PW + 1)'(DEPTH));
   assign empty = (count_q == '0);
   assign doPush = pushValid && !full;
   assign doPop = pop && !empty;
   assign rdPtrNext = doPop ? PW'(rdPtr_q + 1'b1) : rdPtr_q;

   // storage
   always_ff @(posedge clock) begin
      if (doPush) begin
         mem[wrPtr_q] <= pushData;
      end
   end

   // pointers and fill level
   always_ff @(posedge clock) begin
      if (rst) begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
         count_q <= '0;
      end else begin
         if (doPush) begin
            wrPtr_q <= PW'(wrPtr_q + 1'b1);
         end
         rdPtr_q <= rdPtrNext;
         count_q <= (PW + 1)'(count_q + doPush - doPop);
      end
   end

   // registered head with bypass so a fresh entry shows at once
   always_ff @(posedge clock) begin
      if (rst) begin
         headData_q <= '0;
      end else if (doPush && (wrPtr_q == rdPtrNext)) begin
         headData_q <= pushData;
      end else begin
         headData_q <= mem[rdPtrNext];
      end
   end
endmodule
`default_nettype wire

//--- adc_ctrl_sva.sv
`include "adc_ctrl_defs.svh"
`default_nettype none
module adc_ctrl_sva #(
   parameter int STARTUP_CYCLES = 4
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic [23:0] busAddr,
   input wire logic busWrite,
   input wire logic busRead,
   input wire logic [15:0] busWData,
   input wire logic [15:0] busRData_q,
   input wire logic busAck_q,
   input wire logic convStart_q,
   input wire logic converterReady_q,
   input wire logic analogPowerUp_q,
   input wire logic convClockEnable_q,
   input wire logic [4:0] plateDrive_q,
   input wire logic converterIrqLine_q,
   input wire logic converterWakeupLine_q
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);
   // bus handshake
   a_ack_after_req: assert property ((busRead || busWrite) |=> busAck_q)
      else $error("no ack after request");
   a_no_spurious_ack: assert property (!(busRead || busWrite) |=> !busAck_q)
      else $error("ack without request");
   a_unmapped_zero: assert property (busRead && !(busAddr inside {`GLB_ADDR, `AUX_ADDR,
      `TRIG_ADDR, `START_ADDR, `DLY_ADDR, `RES_ADDR}) |=> busRData_q == 16'h0000)
      else $error("unmapped read not zero");
   // power and clock gating follow the written enable bit
   a_power_follows_bit: assert property (busWrite && busAddr == `GLB_ADDR |=>
      ##1 analogPowerUp_q == $past(busWData[`GLB_ENABLE_BIT], 2)
      && convClockEnable_q == analogPowerUp_q)
      else $error("analog power does not follow enable bit");
   a_disabled_quiet: assert property ((!convClockEnable_q) [*2] |->
      !converterReady_q && !convStart_q && plateDrive_q == 5'h00)
      else $error("activity while disabled");
   a_ready_after_enable: assert property ($rose(convClockEnable_q) |->
      ##[0:STARTUP_CYCLES] converterReady_q)
      else $error("converter not ready in time");
   // conversion start
   a_start_when_ready: assert property (convStart_q |-> converterReady_q)
      else $error("start while not ready");
   a_start_single: assert property (convStart_q |=> !convStart_q)
      else $error("start pulse too long");
   // done signalling
   a_irq_implies_wake: assert property (converterIrqLine_q |-> converterWakeupLine_q)
      else $error("irq without wake-up");
   a_read_drops_irq: assert property (busRead && busAddr == `RES_ADDR |->
      ##[1:2] !converterIrqLine_q)
      else $error("irq did not drop after result read");
endmodule
`default_nettype wire

//--- analog_model.sv
`default_nettype none
module analog_model (
   input wire logic clock,
   input wire logic rst,
   input wire logic startReq,
   input wire logic [11:0] code,
   output logic convDone,
   output logic [11:0] convData
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] waitCnt_q;
   // fixed conversion time, data only valid alongside done
   always_ff @(posedge clock) begin
      if (rst) begin
         waitCnt_q <= 3'h0;
         convDone <= 1'b0;
         convData <= 12'h000;
      end else begin
         convDone <= (waitCnt_q == 3'h1);
         convData <= (waitCnt_q == 3'h1) ? code : ~convData; // stale data flips
         if (startReq) begin
            waitCnt_q <= 3'h5;
         end else if (waitCnt_q != 3'h0) begin
            waitCnt_q <= waitCnt_q - 3'h1;
         end
      end
   end
endmodule
`default_nettype wire

//--- testbench.sv
`include "adc_ctrl_defs.svh"
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int STARTUP = 4;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic busWrite = 1'b0, busRead = 1'b0, freezePin = 1'b0, asyncTrigPin = 1'b0;
   logic penDownPin = 1'b0;
   logic [23:0] busAddr = 24'h00_0000;
   logic [15:0] busWData = 16'h0000;
   logic [11:0] code = 12'h000;
   logic busAck_q, convDone, convStart_q, converterReady_q, analogPowerUp_q;
   logic convClockEnable_q, auxClockSelect_q, inputSourceSelect_q, differentialSelect_q;
   logic muxOutputEnable_q, converterIrqLine_q, converterWakeupLine_q;
   logic [1:0] clockDivSelect_q;
   logic [2:0] channelSelect_q;
   logic [3:0] positiveRefSelect_q, negativeRefSelect_q;
   logic [4:0] plateDrive_q;
   logic [11:0] convData;
   logic [15:0] busRData_q, rd;
   int errors = 0, checks = 0;
   // free-running system clock
   always #2.5 clock = ~clock;
   adc_ctrl #(.STARTUP_CYCLES(STARTUP)) adc_ctrl_inst (.clock, .rst, .busAddr, .busWrite,
      .busRead, .busWData, .busRData_q, .busAck_q, .freezePin, .asyncTrigPin, .penDownPin,
      .convDone, .convData, .convStart_q, .converterReady_q, .analogPowerUp_q,
      .convClockEnable_q, .auxClockSelect_q, .clockDivSelect_q, .inputSourceSelect_q,
      .differentialSelect_q, .channelSelect_q, .muxOutputEnable_q, .positiveRefSelect_q,
      .negativeRefSelect_q, .plateDrive_q, .converterIrqLine_q, .converterWakeupLine_q);
   analog_model analog_model_inst (.clock, .rst, .startReq(convStart_q), .code, .convDone,
      .convData);
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks=%0d errors=%0d", checks, errors);
      if (errors == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   // one-cycle strobe, ack and data taken one cycle later
   task automatic xfer(input logic rdNotWr, input logic [23:0] a, input logic [15:0] d);
      @(posedge clock);
      busAddr <= a;
      busWData <= d;
      busRead <= rdNotWr;
      busWrite <= !rdNotWr;
      @(posedge clock);
      busRead <= 1'b0;
      busWrite <= 1'b0;
      #1;
      check(16'(busAck_q), 16'h0001);
      rd = busRData_q;
   endtask
   task automatic wr(input logic [23:0] a, input logic [15:0] d);
      xfer(1'b0, a, d);
   endtask
   task automatic rdchk(input logic [23:0] a, input logic [15:0] exp);
      xfer(1'b1, a, 16'h0000);
      check(rd, exp);
   endtask
   // start a conversion and wait for the result to land
   task automatic convert(input logic [11:0] c);
      int n = 0;
      @(posedge clock) code <= c;
      wr(`START_ADDR, 16'h0000);
      while (convDone !== 1'b1 && n < 40) begin
         @(posedge clock);
         #1;
         n++;
      end
      check(16'(n < 40), 16'h0001);
      cyc(3);
   endtask
   task automatic t_reset_and_lock();
      rdchk(`GLB_ADDR, 16'h0000);
      check({8'h00, positiveRefSelect_q, negativeRefSelect_q}, 16'h0011);
      wr(`DLY_ADDR, 16'h00FF);
      rdchk(`DLY_ADDR, 16'h0000);
      wr(`TRIG_ADDR, 16'h0005);
      rdchk(`TRIG_ADDR, 16'h0000);
      wr(`AUX_ADDR, 16'h0007);
      rdchk(`AUX_ADDR, 16'h0007);
      check({auxClockSelect_q, clockDivSelect_q}, 16'h0007);
      check({plateDrive_q, convClockEnable_q}, 16'h0000);
      wr(`AUX_ADDR, 16'h0000);
   endtask
   task automatic t_enable();
      int n = 0;
      wr(`GLB_ADDR, 16'h0001);
      check(16'(converterReady_q), 16'h0000);
      while (converterReady_q !== 1'b1 && n < 20) begin
         @(posedge clock);
         #1;
         n++;
      end
      check(16'(n <= STARTUP), 16'h0001);
      check(16'(analogPowerUp_q), 16'h0001);
   endtask
   task automatic t_map();
      wr(`GLB_ADDR, 16'hFE29);
      rdchk(`GLB_ADDR, 16'hDE29);
      cyc(2);
      check({positiveRefSelect_q, negativeRefSelect_q}, 16'h0088);
      check({channelSelect_q, muxOutputEnable_q}, 16'h000B);
      wr(`TRIG_ADDR, 16'hFFFF);
      rdchk(`TRIG_ADDR, 16'h0007);
      wr(`TRIG_ADDR, 16'h0000);
      wr(`DLY_ADDR, 16'hA5C3);
      rdchk(`DLY_ADDR, 16'hA5C3);
      wr(`DLY_ADDR, 16'h0000);
      rdchk(`START_ADDR, 16'h0000);
      rdchk(24'hFF_F3CC, 16'h0000);
   endtask
   task automatic t_queue();
      convert(12'hFFF);
      convert(12'h123);
      convert(12'h456);
      convert(12'h789);
      convert(12'hABC);
      check({converterIrqLine_q, converterWakeupLine_q}, 16'h0003);
      rdchk(`RES_ADDR, 16'hA7FF);
      rdchk(`RES_ADDR, 16'h8123);
      rdchk(`RES_ADDR, 16'h8456);
      @(posedge clock) freezePin <= 1'b1;
      cyc(4);
      rdchk(`RES_ADDR, 16'h8789);
      rdchk(`RES_ADDR, 16'h8789);
      convert(12'h234);
      check(16'(converterIrqLine_q), 16'h0001);
      @(posedge clock) freezePin <= 1'b0;
      cyc(4);
      rdchk(`RES_ADDR, 16'h8789);
      rdchk(`RES_ADDR, 16'h8234);
      cyc(3);
      check({converterIrqLine_q, converterWakeupLine_q}, 16'h0000);
   endtask
   task automatic t_differential_select_pen();
      wr(`GLB_ADDR, 16'h0007);
      convert(12'hFFF);
      rdchk(`RES_ADDR, 16'h8FFF);
      check({inputSourceSelect_q, differentialSelect_q}, 16'h0003);
      wr(`GLB_ADDR, 16'h0141);
      @(posedge clock) penDownPin <= 1'b1;
      cyc(5);
      check({plateDrive_q, converterWakeupLine_q}, 16'h0013);
      @(posedge clock) penDownPin <= 1'b0;
   endtask
   // external trigger: unprimed edge ignored, primed and automatic edges convert
   task automatic t_ext_trig();
      wr(`GLB_ADDR, 16'h0001);
      wr(`TRIG_ADDR, 16'h0002);
      @(posedge clock) code <= 12'h3C5;
      asyncTrigPin <= 1'b1;
      cyc(8);
      rdchk(`AUX_ADDR, 16'h0000);
      @(posedge clock) asyncTrigPin <= 1'b0;
      wr(`START_ADDR, 16'h0000);
      rdchk(`AUX_ADDR, 16'h2000);
      @(posedge clock) asyncTrigPin <= 1'b1;
      cyc(20);
      check({converterWakeupLine_q, converterIrqLine_q}, 16'h0002);
      rdchk(`AUX_ADDR, 16'h0000);
      rdchk(`RES_ADDR, 16'h83C5);
      wr(`TRIG_ADDR, 16'h0007);
      @(posedge clock) code <= 12'h5A6;
      asyncTrigPin <= 1'b0;
      cyc(20);
      rdchk(`RES_ADDR, 16'h85A6);
      wr(`TRIG_ADDR, 16'h0000);
   endtask
   task automatic t_disable();
      int starts = 0;
      wr(`GLB_ADDR, 16'h0001);
      wr(`DLY_ADDR, 16'h00C8);
      wr(`START_ADDR, 16'h0000);
      cyc(3);
      rdchk(`AUX_ADDR, 16'h4000);
      wr(`GLB_ADDR, 16'h0000);
      rdchk(`AUX_ADDR, 16'h0000);
      wr(`GLB_ADDR, 16'h0001);
      repeat (260) begin
         @(posedge clock);
         if (convStart_q !== 1'b0) starts++;
      end
      check(16'(starts), 16'h0000);
   endtask
   // cut a hang short
   initial begin
      #50us;
      errors++;
      tally_and_finish();
   end
   initial begin
      repeat (20) @(posedge clock);
      rst <= 1'b0;
      t_reset_and_lock();
      t_enable();
      t_map();
      t_queue();
      t_differential_select_pen();
      t_ext_trig();
      t_disable();
      tally_and_finish();
   end
endmodule
bind adc_ctrl adc_ctrl_sva #(.STARTUP_CYCLES(STARTUP_CYCLES)) adc_ctrl_sva_inst (.clock, .rst,
   .busAddr, .busWrite, .busRead, .busWData, .busRData_q, .busAck_q, .convStart_q,
   .converterReady_q, .analogPowerUp_q, .convClockEnable_q, .plateDrive_q,
   .converterIrqLine_q, .converterWakeupLine_q);
`default_nettype wire
